// >>> dv/thp_ctrl_checker.sv
// Assertion checker for the transmit path overhead register bank.
// Assumes it is bound to thp_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module thp_ctrl_checker
    import thp_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Frame side
    input wire thp_alarm_t alarm_in,
    input wire thp_slot_t  slot_in,
    input wire logic [7:0] oh_byte,
    input wire logic       oh_valid,
    input wire logic       frame_marker_out,
    input wire logic       path_ais_out
);
    // ------------------------------------------------------------------
    // Register mirrors
    // ------------------------------------------------------------------
    logic [7:0] cfg_reg, src_reg, lbl_reg, k3_reg, rdi_reg;  // Copies of written regs
    logic       any_slot, g1_int, g1_hw;                     // Slot conditions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Track register writes seen at the port
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_reg <= RST_PATH_CFG;
            src_reg <= RST_SRC_CFG;
            lbl_reg <= RST_LABEL;
            k3_reg  <= RST_K3;
            rdi_reg <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_PATH_CFG) cfg_reg <= reg_wdata;
            if (reg_addr == ADDR_SRC_CFG) src_reg <= reg_wdata;
            if (reg_addr == ADDR_LABEL) lbl_reg <= reg_wdata;
            if (reg_addr == ADDR_K3) k3_reg <= reg_wdata;
            if (reg_addr == ADDR_RDI) rdi_reg <= reg_wdata;
        end
    end

    // Slot qualifiers
    assign any_slot = slot_in.j1_slot | slot_in.c2_slot | slot_in.g1_slot | slot_in.k3_slot
                    | slot_in.b3_slot | slot_in.n1_slot | slot_in.other_slot;
    assign g1_int   = slot_in.g1_slot && !src_reg[SRC_G1] && !src_reg[SRC_PASS];
    assign g1_hw    = g1_int && !cfg_reg[CFG_RDI];

    // ------------------------------------------------------------------
    // Marker pulse shapes
    // ------------------------------------------------------------------
    sequence s_single;
        frame_marker_out ##1 !frame_marker_out ##1 !frame_marker_out;
    endsequence
    sequence s_double;
        frame_marker_out ##1 !frame_marker_out ##1 frame_marker_out;
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_RDATA_IDLE: assert property (
        !reg_rd |=> reg_rdata == ZERO_BYTE) else $error("read data not zero when idle");
    AST_SLOT_VALID: assert property (
        any_slot |=> oh_valid) else $error("no byte valid after slot strobe");
    AST_MARK_SGL: assert property (
        slot_in.j1_slot && !cfg_reg[CFG_MARKER] |=> s_single) else $error("bad single marker");
    AST_MARK_DBL: assert property (
        slot_in.j1_slot && cfg_reg[CFG_MARKER] && slot_in.h4_phase == MFRAME_START
        |=> s_double) else $error("bad double marker");
    AST_LABEL: assert property (
        slot_in.c2_slot && !src_reg[SRC_C2] && !src_reg[SRC_PASS] && !cfg_reg[CFG_UNEQ]
        |=> oh_byte == lbl_reg) else $error("C2 byte differs from register");
    AST_K3: assert property (
        slot_in.k3_slot && !src_reg[SRC_K3] && !src_reg[SRC_PASS]
        |=> oh_byte == k3_reg) else $error("K3 byte differs from register");
    AST_RDI_AIS: assert property (
        g1_hw && (alarm_in.au_alarm_state || alarm_in.pointer_loss_state)
        |=> oh_byte[3:1] == RDI_AIS_LOP) else $error("RDI code for AIS wrong");
    AST_RDI_PROC: assert property (
        g1_int && cfg_reg[CFG_RDI] |=> oh_byte[3:0] == rdi_reg[3:0])
        else $error("processor RDI not sent");
    AST_B3_INV: assert property (
        slot_in.b3_slot && cfg_reg[1:0] == INV_ALWAYS && !src_reg[SRC_PASS]
        |=> oh_byte == ~$past(slot_in.b3_calc)) else $error("B3 not inverted");
    AST_AIS: assert property (
        (src_reg[SRC_PASS] && cfg_reg[CFG_AIS]) [*2] |-> path_ais_out)
        else $error("path AIS not raised");
endmodule : thp_ctrl_checker

bind thp_ctrl thp_ctrl_checker u_chk (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .alarm_in(alarm_in), .slot_in(slot_in), .oh_byte(oh_byte), .oh_valid(oh_valid),
    .frame_marker_out(frame_marker_out), .path_ais_out(path_ais_out));

// >>> dv/tx_path_overhead_control_test.sv
// Self-checking bench for the transmit path overhead register bank.
// Assumes thp_pkg, thp_ctrl and the bound checker are compiled first.
`timescale 1ns/1ps
module tx_path_overhead_control_test;
    import thp_pkg::*;
    logic       core_clk, nrst, reg_wr, reg_rd, oh_valid, frame_marker_out, path_ais_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, oh_byte, got, expv;
    logic [7:0] tmem [64];  // Expected trace string
    logic [2:0] mk;         // Marker samples after a slot
    thp_alarm_t alarm_in;
    thp_slot_t  slot_in, cur;
    int         bad_count, total_checks, seed, i;

    thp_ctrl dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .alarm_in(alarm_in), .slot_in(slot_in), .oh_byte(oh_byte), .oh_valid(oh_valid),
        .frame_marker_out(frame_marker_out), .path_ais_out(path_ais_out));

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Compare and count
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle register read, data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        got = reg_rdata;
    endtask : rd

    // One slot strobe with fresh random side bytes
    task automatic slot(input int k, input logic [1:0] h);
        thp_slot_t s;
        s             = '0;
        s.h4_phase    = h;
        s.b3_calc     = 8'($random(seed));
        s.pass_byte   = 8'($random(seed));
        s.serial_byte = 8'($random(seed));
        s.rei_count   = 4'($random(seed));
        s.j1_slot     = (k == 0);
        s.frame_start = (k == 0);
        s.c2_slot     = (k == 1);
        s.g1_slot     = (k == 2);
        s.k3_slot     = (k == 3);
        s.b3_slot     = (k == 4);
        s.n1_slot     = (k == 5);
        cur           = s;
        @(posedge core_clk);
        slot_in <= s;
        @(posedge core_clk);
        slot_in <= '0;
        @(negedge core_clk);
        got   = oh_byte;
        mk[2] = frame_marker_out;
        @(negedge core_clk);
        mk[1] = frame_marker_out;
        @(negedge core_clk);
        mk[0] = frame_marker_out;
    endtask : slot

    // Hardware RDI code from alarm levels
    function automatic logic [2:0] rdi_exp(input thp_alarm_t a);
        if (a.au_alarm_state || a.pointer_loss_state) return 3'h5;
        if (a.rdi_on_label_mismatch_en && a.label_mismatch_state) return 3'h4;
        if ((a.rdi_on_unequipped_en && a.unequipped_state) || a.trace_mismatch_state) return 3'h6;
        return 3'h0;
    endfunction : rdi_exp

    // Load, read back and transmit a trace string of n bytes
    task automatic trace_run(input int n);
        int j;
        wr(8'h71, (n == 64) ? 8'h20 : 8'h00);
        wr(8'h75, 8'h02);
        wr(8'h75, 8'h03);
        for (j = 0; j < n; j++) begin
            tmem[j] = 8'($random(seed));
            wr(8'h76, tmem[j]);
        end
        for (j = 0; j < n; j++) begin
            rd(8'h76);
            chk(got, tmem[j]);
        end
        wr(8'h75, 8'h00);
        rd(8'h76);
        chk(got, tmem[0]);
        for (j = 0; j <= n; j++) begin
            slot(0, 2'h1);
            chk(got, tmem[j % n]);
        end
        wr(8'h75, 8'h01);
        slot(0, 2'h1);
        chk(got, tmem[0]);
        $display("TB: trace test of %0d bytes done", n);
    endtask : trace_run

    // Counts and verdict
    task automatic print_verdict;
        $display("TB: checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Watchdog
    initial begin
        #2ms;
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        seed = 32'hf0541b55;
        {bad_count, total_checks} = '0;
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        alarm_in = '0;
        slot_in  = '0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(8'h72);
        chk(got, 8'h01);
        rd(8'h73);
        chk(got, 8'h00);
        rd(8'h75);
        chk(got, 8'h00);
        rd(8'h7f);
        chk(got, 8'h00);
        for (i = 0; i < 4; i++) begin
            slot(0, i[1:0]);
            chk(got, 8'h01);
            chk({5'h00, mk}, (i == 0) ? 8'h05 : 8'h04);
        end
        wr(8'h71, 8'h00);
        slot(0, 2'h0);
        chk({5'h00, mk}, 8'h04);
        $display("TB: reset and marker test done");
        for (i = 0; i < 4; i++) begin
            expv = 8'($random(seed));
            wr(8'h72, expv);
            slot(1, 2'h0);
            chk(got, expv);
            wr(8'h73, ~expv);
            slot(3, 2'h0);
            chk(got, ~expv);
        end
        for (i = 0; i < 16; i++) begin
            alarm_in <= thp_alarm_t'(7'($random(seed)) & ((i < 6) ? 7'h07 : 7'h7f));
            slot(2, 2'h0);
            chk({5'h00, got[3:1]}, {5'h00, rdi_exp(alarm_in)});
            chk({4'h0, got[7:4]}, {4'h0, cur.rei_count});
        end
        wr(8'h71, 8'h0c);
        for (i = 0; i < 3; i++) begin
            expv = 8'($random(seed));
            wr(8'h74, expv);
            slot(2, 2'h0);
            chk({4'h0, got[3:0]}, {4'h0, expv[3:0]});
            chk({4'h0, got[7:4]}, 8'h00);
        end
        wr(8'h70, 8'ha0);
        slot(2, 2'h0);
        chk(got, cur.serial_byte);
        wr(8'h70, 8'h80);
        $display("TB: byte source test done");
        for (i = 0; i < 4; i++) begin
            wr(8'h71, i[7:0]);
            slot(4, 2'h0);
            chk(got, (i >= 2) ? ~cur.b3_calc : cur.b3_calc);
            slot(4, 2'h0);
            chk(got, (i == 2) ? ~cur.b3_calc : cur.b3_calc);
        end
        wr(8'h71, 8'h40);
        slot(1, 2'h0);
        chk(got, 8'h00);
        slot(5, 2'h0);
        chk(got, 8'h00);
        slot(4, 2'h0);
        chk(got, cur.b3_calc);
        slot(0, 2'h1);
        chk(got, 8'h00);
        wr(8'h70, 8'h00);
        slot(0, 2'h1);
        chk(got, 8'h01);
        wr(8'h70, 8'h80);
        $display("TB: parity and unequipped test done");
        trace_run(16);
        trace_run(64);
        wr(8'h70, 8'h84);
        wr(8'h71, 8'h00);
        slot(1, 2'h0);
        chk(got, cur.pass_byte);
        wr(8'h71, 8'h10);
        slot(3, 2'h0);
        chk(got, 8'hff);
        chk({7'h00, path_ais_out}, 8'h01);
        wr(8'h71, 8'h00);
        slot(1, 2'h0);
        chk({7'h00, path_ais_out}, 8'h00);
        $display("TB: path alarm test done");
        print_verdict();
    end
endmodule : tx_path_overhead_control_test

// >>> rtl/thp_ctrl.sv
// Transmit path overhead control: registers, trace store and byte muxing.
// Assumes frame slot strobes from a transmit assembler on core_clk.
`timescale 1ns/1ps

// Function
// (R1) Marker bit clear: single J1 pulse each frame
// (R2) Marker bit set: double pulse at multiframe start
// (R3) Unequipped: C2 N1 zero, valid B3
// (R4) Trace length 16 or 64 bytes
// (R5) Force AIS when all overhead passes through
// (R6) REI source: hardware feedback or zeros
// (R7) Hardware RDI: AIS or LOP gives 101
// (R8) Hardware RDI: label mismatch gives 100
// (R9) Hardware RDI: unequipped/trace mismatch 110, else 000
// (R10) Processor RDI and spare bit into G1
// (R11) B3 inversion: none, always, one frame
// (R12) Processor C2 byte, reset 01
// (R13) Processor K3 byte, reset 00
// (R14) Access off: transmitter advances trace pointer
// (R15) Access on: processor advances pointer, send 01
// (R16) Pointer clears on rising clear bit
// (R17) Software moves trace string one byte each
// (R18) G1 source select: serial input or internal
// (R19) Unequipped J1 zero when configured
// (R20) One trace byte per frame, wrapping pointer
module thp_ctrl
    import thp_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Receive-side alarm status
    input  wire thp_alarm_t alarm_in,
    // Frame assembler side
    input  wire thp_slot_t  slot_in,
    output logic      [7:0] oh_byte,
    output logic            oh_valid,
    output logic            frame_marker_out,
    output logic            path_ais_out
);

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_reg;  // Two-stage release
    logic       rst_n;         // Synchronised reset

    // Release reset two edges after nrst rises
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    logic [7:0] trace_mem [64];  // Trace string store
    thp_state_t st_reg;          // Registered state
    thp_state_t st_next;         // Next state

    // Decoded strobes
    logic       wr_trace;        // Processor write of string byte
    logic       rd_trace;        // Processor read of string byte
    logic       clr_rise;        // Pointer clear edge
    logic [5:0] ptr_wrap;        // Last pointer value
    logic [7:0] trace_byte;      // Byte at pointer
    logic [7:0] g1_internal;     // Internally built G1
    logic [2:0] rdi_hw;          // Hardware RDI code
    logic       pass_all;        // All overhead passes through
    logic       unequip;         // Unequipped transmission

    // Address match helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    assign wr_trace   = reg_wr && hit(reg_addr, ADDR_TRACE_DAT);
    assign rd_trace   = reg_rd && hit(reg_addr, ADDR_TRACE_DAT);
    assign clr_rise   = reg_wr && hit(reg_addr, ADDR_TRACE_CTL)
                        && reg_wdata[TCTL_CLR] && !st_reg.clr_last;  // [R16]
    assign ptr_wrap   = st_reg.path_cfg[CFG_LEN] ? LEN_LONG : LEN_SHORT;  // [R4]
    assign trace_byte = trace_mem[st_reg.ptr];
    assign pass_all   = st_reg.src_cfg[SRC_PASS];
    assign unequip    = st_reg.path_cfg[CFG_UNEQ];

    // ------------------------------------------------------------------
    // Trace string store
    // ------------------------------------------------------------------
    // Processor writes one byte at the pointer
    always_ff @(posedge core_clk) begin
        if (wr_trace) begin
            trace_mem[st_reg.ptr] <= reg_wdata;  // [R17]
        end
    end

    // ------------------------------------------------------------------
    // G1 assembly
    // ------------------------------------------------------------------
    // Hardware RDI priority chain
    always_comb begin
        if (alarm_in.au_alarm_state || alarm_in.pointer_loss_state) begin
            rdi_hw = RDI_AIS_LOP;  // [R7]
        end else if (alarm_in.rdi_on_label_mismatch_en
                     && alarm_in.label_mismatch_state) begin
            rdi_hw = RDI_LABEL;  // [R8]
        end else if ((alarm_in.rdi_on_unequipped_en && alarm_in.unequipped_state)
                     || alarm_in.trace_mismatch_state) begin
            rdi_hw = RDI_CONN;  // [R9]
        end else begin
            rdi_hw = RDI_NONE;  // [R9]
        end
    end

    // REI nibble and RDI/spare nibble
    always_comb begin
        g1_internal[7:4] = st_reg.path_cfg[CFG_REI] ? 4'h0 : slot_in.rei_count;  // [R6]
        if (st_reg.path_cfg[CFG_RDI]) begin
            g1_internal[3:0] = st_reg.rdi;  // [R10]
        end else begin
            g1_internal[3:0] = {rdi_hw, 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.oh_valid = 1'b0;
        st_next.marker   = 1'b0;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_PATH_CFG: st_next.path_cfg = reg_wdata;
                ADDR_SRC_CFG:  st_next.src_cfg  = reg_wdata;
                ADDR_LABEL:    st_next.label    = reg_wdata;  // [R12]
                ADDR_K3:       st_next.k3       = reg_wdata;  // [R13]
                ADDR_RDI:      st_next.rdi      = reg_wdata[3:0];
                ADDR_TRACE_CTL: begin
                    st_next.acc      = reg_wdata[TCTL_ACC];
                    st_next.clr_last = reg_wdata[TCTL_CLR];
                end
                default: ;
            endcase
        end

        // Read data, unmapped reads return zero
        st_next.rd_data = ZERO_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_PATH_CFG:  st_next.rd_data = st_reg.path_cfg;
                ADDR_SRC_CFG:   st_next.rd_data = st_reg.src_cfg;
                ADDR_LABEL:     st_next.rd_data = st_reg.label;
                ADDR_K3:        st_next.rd_data = st_reg.k3;
                ADDR_RDI:       st_next.rd_data = {4'h0, st_reg.rdi};
                ADDR_TRACE_DAT: st_next.rd_data = trace_byte;  // [R17]
                default:        st_next.rd_data = ZERO_BYTE;
            endcase
        end

        // Trace pointer movement
        if (clr_rise) begin
            st_next.ptr = 6'h0;  // [R16]
        end else if (st_reg.acc && (wr_trace || rd_trace)) begin
            st_next.ptr = (st_reg.ptr >= ptr_wrap) ? 6'h0 : st_reg.ptr + 6'h1;  // [R15]
        end else if (!st_reg.acc && slot_in.j1_slot) begin
            st_next.ptr = (st_reg.ptr >= ptr_wrap) ? 6'h0 : st_reg.ptr + 6'h1;  // [R14] [R20]
        end

        // Frame marker: single pulse at J1, second pulse at multiframe start
        if (slot_in.j1_slot) begin
            st_next.marker        = 1'b1;  // [R1]
            st_next.marker_second = st_reg.path_cfg[CFG_MARKER]
                                    && (slot_in.h4_phase == MFRAME_START);  // [R2]
        end else if (st_reg.marker_second && !st_reg.marker) begin
            // Second pulse after one low cycle, then disarm
            st_next.marker        = 1'b1;  // [R2]
            st_next.marker_second = 1'b0;
        end

        // Single-frame B3 inversion tracking
        if (st_reg.path_cfg[1:0] != INV_ONCE) begin
            st_next.inv_once_done = 1'b0;
        end else if (slot_in.b3_slot) begin
            st_next.inv_once_done = 1'b1;  // [R11]
        end

        // Path AIS request
        st_next.path_ais = pass_all && st_reg.path_cfg[CFG_AIS];  // [R5]

        // Overhead byte selection
        if (slot_in.j1_slot) begin
            st_next.oh_valid = 1'b1;
            if (pass_all) begin
                st_next.oh_byte = slot_in.pass_byte;
            end else if (unequip && st_reg.src_cfg[SRC_UNEQ_J1]) begin
                st_next.oh_byte = ZERO_BYTE;  // [R19] [R3]
            end else if (st_reg.src_cfg[SRC_J1]) begin
                st_next.oh_byte = slot_in.serial_byte;
            end else if (st_reg.acc) begin
                st_next.oh_byte = TRACE_IDLE;  // [R15]
            end else begin
                st_next.oh_byte = trace_byte;  // [R20]
            end
        end else if (slot_in.c2_slot) begin
            st_next.oh_valid = 1'b1;
            if (pass_all) begin
                st_next.oh_byte = slot_in.pass_byte;
            end else if (unequip) begin
                st_next.oh_byte = ZERO_BYTE;  // [R3]
            end else if (st_reg.src_cfg[SRC_C2]) begin
                st_next.oh_byte = slot_in.serial_byte;
            end else begin
                st_next.oh_byte = st_reg.label;  // [R12]
            end
        end else if (slot_in.n1_slot) begin
            st_next.oh_valid = 1'b1;
            st_next.oh_byte  = (unequip && !pass_all) ? ZERO_BYTE : slot_in.pass_byte;  // [R3]
        end else if (slot_in.g1_slot) begin
            st_next.oh_valid = 1'b1;
            if (pass_all) begin
                st_next.oh_byte = slot_in.pass_byte;
            end else if (st_reg.src_cfg[SRC_G1]) begin
                st_next.oh_byte = slot_in.serial_byte;  // [R18]
            end else begin
                st_next.oh_byte = g1_internal;  // [R18]
            end
        end else if (slot_in.k3_slot) begin
            st_next.oh_valid = 1'b1;
            if (pass_all) begin
                st_next.oh_byte = slot_in.pass_byte;
            end else if (st_reg.src_cfg[SRC_K3]) begin
                st_next.oh_byte = slot_in.serial_byte;
            end else begin
                st_next.oh_byte = st_reg.k3;  // [R13]
            end
        end else if (slot_in.b3_slot) begin
            st_next.oh_valid = 1'b1;
            // Parity always recomputed, so unequipped B3 stays valid
            if (st_reg.path_cfg[1:0] == INV_ALWAYS
                || (st_reg.path_cfg[1:0] == INV_ONCE && !st_reg.inv_once_done)) begin
                st_next.oh_byte = ~slot_in.b3_calc;  // [R11]
            end else begin
                st_next.oh_byte = slot_in.b3_calc;  // [R11] [R3]
            end
        end else if (slot_in.other_slot) begin
            st_next.oh_valid = 1'b1;
            st_next.oh_byte  = slot_in.pass_byte;
        end

        // AIS overrides every path byte
        if (st_reg.path_ais && st_next.oh_valid) begin
            st_next.oh_byte = AIS_BYTE;  // [R5]
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg               <= '0;
            st_reg.path_cfg      <= RST_PATH_CFG;
            st_reg.src_cfg       <= RST_SRC_CFG;
            st_reg.label         <= RST_LABEL;
            st_reg.k3            <= RST_K3;
            st_reg.rdi           <= RST_RDI;
            st_reg.acc           <= RST_ACC;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata        = st_reg.rd_data;
    assign oh_byte          = st_reg.oh_byte;
    assign oh_valid         = st_reg.oh_valid;
    assign frame_marker_out = st_reg.marker;
    assign path_ais_out     = st_reg.path_ais;

endmodule : thp_ctrl

// >>> rtl/thp_pkg.sv
// Package for the transmit path overhead control register bank.
// Assumes one core clock domain; register port is a plain strobe bus.
package thp_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PATH_CFG   = 8'h71;  // Path configuration
    localparam logic [7:0] ADDR_LABEL     = 8'h72;  // Processor C2 byte
    localparam logic [7:0] ADDR_K3        = 8'h73;  // Processor K3 byte
    localparam logic [7:0] ADDR_RDI       = 8'h74;  // Processor RDI bits
    localparam logic [7:0] ADDR_TRACE_CTL = 8'h75;  // Trace string control
    localparam logic [7:0] ADDR_TRACE_DAT = 8'h76;  // Trace string data
    localparam logic [7:0] ADDR_SRC_CFG   = 8'h70;  // Source select bits

    // ------------------------------------------------------------------
    // Field positions, path configuration
    // ------------------------------------------------------------------
    localparam int CFG_MARKER   = 7;
    localparam int CFG_UNEQ     = 6;
    localparam int CFG_LEN      = 5;
    localparam int CFG_AIS      = 4;
    localparam int CFG_REI      = 3;
    localparam int CFG_RDI      = 2;
    // Source select register fields
    localparam int SRC_UNEQ_J1  = 7;
    localparam int SRC_K3       = 6;
    localparam int SRC_G1       = 5;
    localparam int SRC_C2       = 4;
    localparam int SRC_J1       = 3;
    localparam int SRC_PASS     = 2;
    // Trace control fields
    localparam int TCTL_ACC     = 1;
    localparam int TCTL_CLR     = 0;

    // ------------------------------------------------------------------
    // Reset values and constant bytes
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PATH_CFG = 8'h80;
    localparam logic [7:0] RST_SRC_CFG  = 8'h80;
    localparam logic [7:0] RST_LABEL    = 8'h01;
    localparam logic [7:0] RST_K3       = 8'h00;
    localparam logic [3:0] RST_RDI      = 4'h0;
    localparam logic       RST_ACC      = 1'b1;
    localparam logic [7:0] TRACE_IDLE   = 8'h01;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    localparam logic [7:0] AIS_BYTE     = 8'hff;
    localparam logic [2:0] RDI_AIS_LOP  = 3'h5;
    localparam logic [2:0] RDI_LABEL    = 3'h4;
    localparam logic [2:0] RDI_CONN     = 3'h6;
    localparam logic [2:0] RDI_NONE     = 3'h0;
    localparam logic [5:0] LEN_SHORT    = 6'h0f;
    localparam logic [5:0] LEN_LONG     = 6'h3f;
    localparam logic [1:0] MFRAME_START = 2'h0;
    localparam logic [1:0] INV_ALWAYS   = 2'h2;
    localparam logic [1:0] INV_ONCE     = 2'h3;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // Alarm inputs from the receive side
    typedef struct packed {
        logic au_alarm_state;
        logic pointer_loss_state;
        logic rdi_on_label_mismatch_en;
        logic label_mismatch_state;
        logic rdi_on_unequipped_en;
        logic unequipped_state;
        logic trace_mismatch_state;
    } thp_alarm_t;

    // Frame-assembler timing and byte requests
    typedef struct packed {
        logic       frame_start;  // One-cycle pulse per frame
        logic [1:0] h4_phase;     // H4 bits 1:0 of this frame
        logic       j1_slot;      // J1 byte request
        logic       c2_slot;
        logic       g1_slot;
        logic       k3_slot;
        logic       b3_slot;
        logic       n1_slot;
        logic       other_slot;   // Any other path byte
        logic [7:0] b3_calc;      // Computed B3 parity
        logic [7:0] pass_byte;    // Received byte for pass-through
        logic [7:0] serial_byte;  // Byte from overhead serial input
        logic [3:0] rei_count;    // Received B3 error feedback
    } thp_slot_t;

    // Whole module state
    typedef struct packed {
        logic [7:0] path_cfg;
        logic [7:0] src_cfg;
        logic [7:0] label;
        logic [7:0] k3;
        logic [3:0] rdi;
        logic       acc;
        logic       clr_last;
        logic [5:0] ptr;
        logic       inv_once_done;
        logic [7:0] rd_data;
        logic [7:0] oh_byte;
        logic       oh_valid;
        logic       marker;
        logic       marker_second;
        logic       path_ais;
    } thp_state_t;

endpackage : thp_pkg
